// ### hdl/cpu_arith_core.v
`timescale 1ns/1ps
`default_nettype none
`include "cpu_arith_regs.vh"

module cpu_arith_core (
   // clock and reset
   input wire sys_clk_i,
   input wire rstn_i,
   // register port
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   // cpu memory bus
   output reg [15:0] mem_addr_o,
   output reg mem_rd_o,
   input wire [7:0] mem_rdata_i,
   // status
   output reg fault_o
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_OP = 3'd1;
   localparam [2:0] ST_ARG1 = 3'd2;
   localparam [2:0] ST_ARG2 = 3'd3;
   localparam [2:0] ST_GAP = 3'd4;
   localparam [2:0] ST_MEM = 3'd5;
   localparam [2:0] ST_HALT = 3'd6;

   localparam [2:0] MD_INLINE = 3'd0;
   localparam [2:0] MD_ZPAGE = 3'd1;
   localparam [2:0] MD_FULL = 3'd2;
   localparam [2:0] MD_IDX_WORD = 3'd3;
   localparam [2:0] MD_IDX_BYTE = 3'd4;
   localparam [2:0] MD_IDX_NOOFS = 3'd5;
   localparam [2:0] MD_STK_WORD = 3'd6;
   localparam [2:0] MD_STK_BYTE = 3'd7;

   localparam [2:0] K_ADD = 3'd0;
   localparam [2:0] K_ADC = 3'd1;
   localparam [2:0] K_AND = 3'd2;
   localparam [2:0] K_STK_ADJ = 3'd3;
   localparam [2:0] K_IDX_ADJ = 3'd4;
   localparam [15:0] PROG_START = `PROG_RST;

   reg [2:0] state;
   reg [7:0] acc;
   reg [7:0] condition_flags_reg;
   reg [7:0] idx_high;
   reg [7:0] idx_low;
   reg [15:0] stack_pointer;
   reg [7:0] progctr_high_byte;
   reg [7:0] progctr_low_byte;
   reg [2:0] mode;
   reg [2:0] kind;
   reg prefix;
   reg postinc;
   reg [7:0] arg_hi;
   reg run;

   reg dec_ok;
   reg [2:0] dec_mode;
   reg [2:0] dec_kind;

   wire [15:0] index_pair;
   wire [15:0] program_counter;
   wire [15:0] pc_inc;
   wire [15:0] pc_after;
   wire [15:0] sext;
   wire [7:0] alu_res;
   wire [7:0] alu_flags;
   wire exec;
   wire host_ok;
   wire wide_arg;

   assign index_pair = {idx_high, idx_low};
   assign program_counter = {progctr_high_byte, progctr_low_byte};
   assign pc_inc = program_counter + 16'h0001;
   // operand fetch ends at pc for memory modes, one further for inline
   assign pc_after = (state == ST_ARG1) ? pc_inc : program_counter;
   assign sext = {{8{mem_rdata_i[7]}}, mem_rdata_i};
   assign exec = (state == ST_MEM) || (state == ST_ARG1 && mode == MD_INLINE);
   assign host_ok = (state == ST_IDLE) || (state == ST_HALT);
   // word offsets and full addresses arrive high byte first
   assign wide_arg = (mode == MD_FULL) || (mode == MD_IDX_WORD) || (mode == MD_STK_WORD);

   arith_flag_unit u_alu (
      .acc_i(acc),
      .operand_i(mem_rdata_i),
      .flags_i(condition_flags_reg),
      .op_i(kind[1:0]),
      .result_o(alu_res),
      .flags_o(alu_flags)
   );

   // sums wrap in 16 bits, so signed and unsigned word offsets agree
   function [15:0] eff_addr;
      input [2:0] md;
      input [7:0] hi;
      input [7:0] lo;
      input [15:0] hx;
      input [15:0] sp;
      begin
         case (md)
            MD_ZPAGE: eff_addr = {`ZPAGE_HIGH, lo};
            MD_FULL: eff_addr = {hi, lo};
            MD_IDX_WORD: eff_addr = hx + {hi, lo};
            MD_IDX_BYTE: eff_addr = hx + {8'h00, lo};
            MD_IDX_NOOFS: eff_addr = hx;
            MD_STK_WORD: eff_addr = sp + {hi, lo};
            MD_STK_BYTE: eff_addr = sp + {8'h00, lo};
            default: eff_addr = hx;
         endcase
      end
   endfunction

   always @*
   begin
      dec_ok = 1'b1;
      dec_mode = MD_INLINE;
      dec_kind = K_ADD;
      if (!prefix && mem_rdata_i == `OPC_STACK_ADJ)
      begin
         dec_kind = K_STK_ADJ;
      end
      else if (!prefix && mem_rdata_i == `OPC_INDEX_ADJ)
      begin
         dec_kind = K_IDX_ADJ;
      end
      else
      begin
         case (mem_rdata_i[3:0])
            `OPL_ADC: dec_kind = K_ADC;
            `OPL_ADD: dec_kind = K_ADD;
            `OPL_AND: dec_kind = K_AND;
            default: dec_ok = 1'b0;
         endcase
         if (prefix)
         begin
            case (mem_rdata_i[7:4])
               `OPH_STK_WORD: dec_mode = MD_STK_WORD;
               `OPH_STK_BYTE: dec_mode = MD_STK_BYTE;
               default: dec_ok = 1'b0;
            endcase
         end
         else
         begin
            case (mem_rdata_i[7:4])
               `OPH_INLINE: dec_mode = MD_INLINE;
               `OPH_ZPAGE: dec_mode = MD_ZPAGE;
               `OPH_FULL: dec_mode = MD_FULL;
               `OPH_IDX_WORD: dec_mode = MD_IDX_WORD;
               `OPH_IDX_BYTE: dec_mode = MD_IDX_BYTE;
               `OPH_IDX_NOOFS: dec_mode = MD_IDX_NOOFS;
               default: dec_ok = 1'b0;
            endcase
         end
      end
   end

   always @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         state <= ST_IDLE;
         acc <= 8'h00;
         condition_flags_reg <= `FLAGS_RST;
         idx_high <= 8'h00;
         idx_low <= 8'h00;
         stack_pointer <= `STK_RST;
         progctr_high_byte <= PROG_START[15:8];
         progctr_low_byte <= PROG_START[7:0];
         mode <= MD_INLINE;
         kind <= K_ADD;
         prefix <= 1'b0;
         postinc <= 1'b0;
         arg_hi <= 8'h00;
         run <= 1'b0;
         fault_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         mem_rd_o <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               mem_rd_o <= 1'b0;
               if (run)
               begin
                  state <= ST_OP;
                  mem_addr_o <= program_counter;
                  mem_rd_o <= 1'b1;
                  prefix <= 1'b0;
               end
            end
            ST_OP:
            begin
               {progctr_high_byte, progctr_low_byte} <= pc_inc;
               mem_addr_o <= pc_inc;
               if (!prefix && mem_rdata_i == `OPC_PREFIX)
               begin
                  prefix <= 1'b1;
               end
               else if (!dec_ok)
               begin
                  fault_o <= 1'b1;
                  state <= ST_HALT;
                  mem_rd_o <= 1'b0;
               end
               else
               begin
                  mode <= dec_mode;
                  kind <= dec_kind;
                  // none of this subset uses the post-increment forms
                  postinc <= 1'b0;
                  if (dec_mode == MD_IDX_NOOFS)
                  begin
                     // no operand bytes, idle cycle keeps the count at three
                     state <= ST_GAP;
                     mem_rd_o <= 1'b0;
                  end
                  else
                  begin
                     state <= ST_ARG1;
                  end
               end
            end
            ST_GAP:
            begin
               state <= ST_MEM;
               mem_rd_o <= 1'b1;
               mem_addr_o <= index_pair;
            end
            ST_ARG1:
            begin
               {progctr_high_byte, progctr_low_byte} <= pc_inc;
               if (wide_arg)
               begin
                  arg_hi <= mem_rdata_i;
                  mem_addr_o <= pc_inc;
                  state <= ST_ARG2;
               end
               else if (mode != MD_INLINE)
               begin
                  mem_addr_o <= eff_addr(mode, 8'h00, mem_rdata_i, index_pair, stack_pointer);
                  state <= ST_MEM;
               end
            end
            ST_ARG2:
            begin
               {progctr_high_byte, progctr_low_byte} <= pc_inc;
               mem_addr_o <= eff_addr(mode, arg_hi, mem_rdata_i, index_pair, stack_pointer);
               state <= ST_MEM;
            end
            ST_MEM:
            begin
               if (postinc)
               begin
                  {idx_high, idx_low} <= index_pair + `POSTINC_STEP;
               end
            end
            ST_HALT:
            begin
               mem_rd_o <= 1'b0;
            end
            default:
            begin
               state <= ST_IDLE;
               mem_rd_o <= 1'b0;
            end
         endcase

         if (exec)
         begin
            case (kind)
               K_ADD, K_ADC, K_AND:
               begin
                  acc <= alu_res;
                  condition_flags_reg <= alu_flags;
               end
               K_STK_ADJ: stack_pointer <= stack_pointer + sext;
               K_IDX_ADJ: {idx_high, idx_low} <= index_pair + sext;
               default: acc <= acc;
            endcase
            // next opcode fetch follows at once, so no cycle is lost
            prefix <= 1'b0;
            mem_addr_o <= pc_after;
            mem_rd_o <= run;
            state <= run ? ST_OP : ST_IDLE;
         end

         if (reg_wr_i)
         begin
            case (reg_addr_i)
               `REG_CTRL:
               begin
                  run <= reg_wdata_i[`CTRL_RUN];
                  if (reg_wdata_i[`CTRL_CLR_FAULT] && state == ST_HALT)
                  begin
                     fault_o <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
               `REG_ACC: if (host_ok) acc <= reg_wdata_i;
               `REG_FLAGS: if (host_ok) condition_flags_reg <= reg_wdata_i & `FLG_WMASK;
               `REG_IDX_HIGH: if (host_ok) idx_high <= reg_wdata_i;
               `REG_IDX_LOW: if (host_ok) idx_low <= reg_wdata_i;
               `REG_STK_HIGH: if (host_ok) stack_pointer[15:8] <= reg_wdata_i;
               `REG_STK_LOW: if (host_ok) stack_pointer[7:0] <= reg_wdata_i;
               `REG_PROG_HIGH: if (host_ok) progctr_high_byte <= reg_wdata_i;
               `REG_PROG_LOW: if (host_ok) progctr_low_byte <= reg_wdata_i;
               default: run <= run;
            endcase
         end
      end
   end

   // read data valid only in the cycle after the strobe
   always @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            `REG_CTRL: reg_rdata_o <= {7'h00, run};
            `REG_STATUS: reg_rdata_o <= {6'h00, fault_o, !host_ok};
            `REG_ACC: reg_rdata_o <= acc;
            `REG_FLAGS: reg_rdata_o <= condition_flags_reg;
            `REG_IDX_HIGH: reg_rdata_o <= idx_high;
            `REG_IDX_LOW: reg_rdata_o <= idx_low;
            `REG_STK_HIGH: reg_rdata_o <= stack_pointer[15:8];
            `REG_STK_LOW: reg_rdata_o <= stack_pointer[7:0];
            `REG_PROG_HIGH: reg_rdata_o <= progctr_high_byte;
            `REG_PROG_LOW: reg_rdata_o <= progctr_low_byte;
            default: reg_rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule // cpu_arith_core

`default_nettype wire

// ### hdl/cpu_arith_regs.vh
`ifndef CPU_ARITH_REGS_VH
`define CPU_ARITH_REGS_VH

// register port offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_ACC 4'h2
`define REG_FLAGS 4'h3
`define REG_IDX_HIGH 4'h4
`define REG_IDX_LOW 4'h5
`define REG_STK_HIGH 4'h6
`define REG_STK_LOW 4'h7
`define REG_PROG_HIGH 4'h8
`define REG_PROG_LOW 4'h9

// control and status bit positions
`define CTRL_RUN 0
`define CTRL_CLR_FAULT 1
`define STAT_BUSY 0
`define STAT_FAULT 1

// condition flag positions
`define FLG_V 7
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0
`define FLG_WMASK 8'h9F

// reset values, zero page high byte and post-increment step
`define FLAGS_RST 8'h08
`define STK_RST 16'h00FF
`define PROG_RST 16'h0000
`define ZPAGE_HIGH 8'h00
`define POSTINC_STEP 16'h0001

// opcodes: whole bytes, then low nibble = operation, high nibble = mode
`define OPC_PREFIX 8'h9E
`define OPC_STACK_ADJ 8'hA7
`define OPC_INDEX_ADJ 8'hAF
`define OPL_ADC 4'h9
`define OPL_ADD 4'hB
`define OPL_AND 4'h4
`define OPH_INLINE 4'hA
`define OPH_ZPAGE 4'hB
`define OPH_FULL 4'hC
`define OPH_IDX_WORD 4'hD
`define OPH_IDX_BYTE 4'hE
`define OPH_IDX_NOOFS 4'hF
`define OPH_STK_WORD 4'hD
`define OPH_STK_BYTE 4'hE

`endif

// ### hdl/arith_flag_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "cpu_arith_regs.vh"

module arith_flag_unit (
   // operands
   input wire [7:0] acc_i,
   input wire [7:0] operand_i,
   input wire [7:0] flags_i,
   input wire [1:0] op_i,
   // result
   output wire [7:0] result_o,
   output reg [7:0] flags_o
);

   localparam [1:0] OP_ADD = 2'd0;
   localparam [1:0] OP_ADC = 2'd1;
   localparam [1:0] OP_AND = 2'd2;

   wire carry_in;
   wire [8:0] sum;
   wire [7:0] res;
   wire zero;
   wire ovf;
   wire half;
   wire cout;

   assign carry_in = (op_i == OP_ADC) ? flags_i[`FLG_C] : 1'b0;
   assign sum = {1'b0, acc_i} + {1'b0, operand_i} + {8'h00, carry_in};
   assign res = (op_i == OP_AND) ? (acc_i & operand_i) : sum[7:0];
   assign result_o = res;
   assign zero = ~|res;
   assign ovf = (acc_i[7] & operand_i[7] & ~res[7]) | (~acc_i[7] & ~operand_i[7] & res[7]);
   assign half = (acc_i[3] & operand_i[3]) | (operand_i[3] & ~res[3]) | (~res[3] & acc_i[3]);
   assign cout = sum[8];

   always @*
   begin
      flags_o = flags_i;
      flags_o[`FLG_N] = res[7];
      flags_o[`FLG_Z] = zero;
      if (op_i == OP_AND)
      begin
         flags_o[`FLG_V] = 1'b0;
      end
      else
      begin
         // mask bit left alone by both adds
         flags_o[`FLG_V] = ovf;
         flags_o[`FLG_H] = half;
         flags_o[`FLG_C] = cout;
      end
   end

endmodule // arith_flag_unit

`default_nettype wire

// ### testbench/cpu_arith_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_core_sva (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // memory bus and status
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic fault_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // opcode classes by high nibble; bench keeps data bytes out of these
   sequence op_hi(logic [3:0] n);
      mem_rd_o && mem_rdata_i[7:4] == n;
   endsequence
   sequence next_byte;
      mem_rd_o && mem_addr_o == $past(mem_addr_o) + 16'h0001;
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read slot");
   inline_len_a: assert property (op_hi(4'hA) |=> next_byte ##1 next_byte)
      else $error("inline instruction length wrong");
   zpage_addr_a: assert property (op_hi(4'hB) ##1 next_byte |=>
      mem_rd_o && mem_addr_o == {8'h00, $past(mem_rdata_i)} ##1
      mem_rd_o && mem_addr_o == $past(mem_addr_o, 3) + 16'h0002)
      else $error("zero page read address or length wrong");
   full_addr_a: assert property (op_hi(4'hC) ##1 next_byte ##1 next_byte |=>
      mem_rd_o && mem_addr_o == {$past(mem_rdata_i, 2), $past(mem_rdata_i)} ##1
      mem_rd_o && mem_addr_o == $past(mem_addr_o, 4) + 16'h0003)
      else $error("full address read wrong");
   word_len_a: assert property (op_hi(4'hD) |=> next_byte ##1 next_byte ##1 mem_rd_o ##1
      (mem_rd_o && mem_addr_o == $past(mem_addr_o, 4) + 16'h0003))
      else $error("word offset instruction length wrong");
   byte_len_a: assert property (op_hi(4'hE) |=> next_byte ##1 mem_rd_o ##1
      (mem_rd_o && mem_addr_o == $past(mem_addr_o, 3) + 16'h0002))
      else $error("byte offset instruction length wrong");
   noofs_len_a: assert property (op_hi(4'hF) |=> !mem_rd_o ##1 mem_rd_o ##1
      (mem_rd_o && mem_addr_o == $past(mem_addr_o, 3) + 16'h0001))
      else $error("plain indexed instruction timing wrong");
   halt_quiet_a: assert property (fault_o |-> !mem_rd_o)
      else $error("memory read while halted");
endmodule // cpu_arith_core_sva
bind cpu_arith_core cpu_arith_core_sva cpu_arith_core_sva_inst (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
   .mem_rdata_i(mem_rdata_i), .fault_o(fault_o));
`default_nettype wire

// ### testbench/prog_data_mem.sv
`timescale 1ns/1ps
`default_nettype none
module prog_data_mem (
   // core side
   input wire logic sys_clk_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic mem_rd_i,
   output logic [7:0] mem_rdata_o,
   // bench loading
   input wire logic load_i,
   input wire logic [15:0] load_addr_i,
   input wire logic [7:0] load_data_i
);
   logic [7:0] cells [0:65535];
   logic [7:0] last = 8'h5A;
   initial
   begin
      for (int i = 0; i < 65536; i++)
         cells[i] = 8'h00;
   end
   always @(posedge sys_clk_i)
   begin
      if (load_i)
         cells[load_addr_i] <= load_data_i;
      if (mem_rd_i)
         last <= mem_rdata_o;
   end
   // not read: show a flipped byte so a stale sample cannot pass
   always_comb mem_rdata_o = mem_rd_i ? cells[mem_addr_i] : ~last;
endmodule // prog_data_mem
`default_nettype wire

// ### testbench/test_cpu_arith_instr_subset.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_arith_regs.vh"
module test_cpu_arith_instr_subset;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [15:0] mem_addr_o;
   logic mem_rd_o;
   logic [7:0] mem_rdata_i;
   logic fault_o;
   logic load = 1'b0;
   logic [15:0] load_addr = 16'h0000;
   logic [7:0] load_data = 8'h00;
   int miscompares = 0;
   int n_checks = 0;
   integer seed = 32'h90843BD8;
   initial forever #4 sys_clk_i = ~sys_clk_i;
   cpu_arith_core cpu_arith_core_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o),
      .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .fault_o(fault_o));
   prog_data_mem prog_data_mem_inst (.sys_clk_i(sys_clk_i), .mem_addr_i(mem_addr_o),
      .mem_rd_i(mem_rd_o), .mem_rdata_o(mem_rdata_i), .load_i(load),
      .load_addr_i(load_addr), .load_data_i(load_data));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge sys_clk_i);
      d = reg_rdata_o;
   endtask
   task automatic ld(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      load <= 1'b1;
      load_addr <= a;
      load_data <= d;
      @(posedge sys_clk_i);
      load <= 1'b0;
   endtask
   // program at 0200, ended by an illegal byte so the core halts
   task automatic run_prog(input logic [7:0] p [$], input logic [15:0] hx, input logic [15:0] sp);
      int n;
      logic [7:0] st;
      p.push_back(8'h00);
      foreach (p[i])
         ld(16'(16'h0200 + i), p[i]);
      wr(`REG_IDX_HIGH, hx[15:8]);
      wr(`REG_IDX_LOW, hx[7:0]);
      wr(`REG_STK_HIGH, sp[15:8]);
      wr(`REG_STK_LOW, sp[7:0]);
      wr(`REG_PROG_HIGH, 8'h02);
      wr(`REG_PROG_LOW, 8'h00);
      wr(`REG_CTRL, 8'h01);
      n = 0;
      while (fault_o !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      check("halt", 16'h0001, {15'h0000, fault_o});
      if (fault_o !== 1'b1)
         tally_and_finish();
      rd(`REG_STATUS, st);
      check("status halted", 16'h0002, {8'h00, st});
      rd(`REG_PROG_LOW, st);
      check("progctr low", 16'(p.size()), {8'h00, st});
      wr(`REG_CTRL, 8'h02);
   endtask
   function automatic logic [15:0] model(input int k, input logic [7:0] a, m, f);
      int c;
      int s;
      int hs;
      logic [7:0] r;
      c = (k == 0) ? int'(f[0]) : 0;
      s = a + m + c;
      hs = a[3:0] + m[3:0] + c;
      r = (k == 2) ? (a & m) : s[7:0];
      if (k == 2)
         return {r, 3'b000, f[4:3], r[7], r == 8'h00, f[0]};
      return {r, a[7] == m[7] && r[7] != a[7], 2'b00, hs > 15, f[3], r[7], r == 8'h00, s > 255};
   endfunction
   initial
   begin
      logic [7:0] a, m, f, d, ii;
      logic [15:0] hx, sp, ea, e, base;
      logic [7:0] p [$];
      logic [7:0] rst_tab [0:9] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'hFF,
         8'h00, 8'h00};
      logic [3:0] hn [0:7] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'hD, 4'hE};
      logic [3:0] lo [0:2] = '{`OPL_ADC, `OPL_ADD, `OPL_AND};
      int nb [0:7] = '{0, 1, 2, 2, 1, 0, 2, 1};
      logic [15:0] ow [0:7] = '{16'h0000, 16'h0040, 16'h1234, 16'h0123, 16'h0090, 16'h0000,
         16'h0123, 16'h0090};
      repeat (3) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         rd(4'(i), d);
         check("reset value", rst_tab[i], d);
      end
      rd(4'hF, d);
      check("unmapped read", 16'h0000, d);
      $display("reset test done");
      for (int k = 0; k < 3; k++)
      begin
         for (int md = 0; md < 8; md++)
         begin
            a = 8'($random(seed));
            m = 8'($random(seed)) & 8'h9F;
            f = 8'($random(seed));
            hx = {1'b1, 15'($random(seed))};
            sp = {1'b1, 15'($random(seed))};
            base = (md > 5) ? sp : (md > 2) ? hx : 16'h0000;
            ea = ow[md] + base;
            p = {};
            if (md > 5)
               p.push_back(`OPC_PREFIX);
            p.push_back({hn[md], lo[k]});
            if (md == 0)
               p.push_back(m);
            if (nb[md] == 2)
               p.push_back(ow[md][15:8]);
            if (nb[md] > 0)
               p.push_back(ow[md][7:0]);
            if (md > 0)
               ld(ea, m);
            wr(`REG_ACC, a);
            wr(`REG_FLAGS, f);
            run_prog(p, hx, sp);
            e = model(k, a, m, f & 8'h9F);
            rd(`REG_ACC, d);
            check("acc", e[15:8], d);
            rd(`REG_FLAGS, d);
            check("flags", e[7:0], d);
            rd(`REG_IDX_HIGH, d);
            check("index high", hx[15:8], d);
         end
      end
      $display("arithmetic test done");
      for (int j = 0; j < 6; j++)
      begin
         ii = (j == 0) ? 8'h80 : (j == 1) ? 8'h7F : (8'($random(seed)) & 8'h9F);
         f = 8'($random(seed));
         hx = 16'($random(seed));
         sp = 16'($random(seed));
         wr(`REG_FLAGS, f);
         p = '{j[0] ? `OPC_INDEX_ADJ : `OPC_STACK_ADJ, ii};
         run_prog(p, hx, sp);
         e = (j[0] ? hx : sp) + {{8{ii[7]}}, ii};
         rd(j[0] ? `REG_IDX_HIGH : `REG_STK_HIGH, d);
         check("adjusted high", e[15:8], d);
         rd(j[0] ? `REG_IDX_LOW : `REG_STK_LOW, d);
         check("adjusted low", e[7:0], d);
         rd(`REG_FLAGS, d);
         check("flags kept", f & 8'h9F, d);
      end
      $display("adjust test done");
      tally_and_finish();
   end
endmodule // test_cpu_arith_instr_subset
`default_nettype wire
